// [core/ctcc_core.sv]
// control, capture and reload registers of an 8-bit and a 16-bit counter/timer
// assumes: cpu register accesses and pin inputs synchronous to clk_sys, one access per cycle
//
// Behaviour
// - the wide counter runs while its run bit is one, stops on a written zero, reads back its state and clears at reset.
// - in output mode the wide counter reloads at terminal count when single-pass is zero and stops there when it is one.
// - in measurement mode with single-pass set the wide counter captures the first edge only, otherwise every edge.
// - terminal count sets the timeout flag, a written one clears it and a written zero leaves it.
// - a wide capture requests an interrupt only when mask bit 2 is one, which resets to zero.
// - a wide timeout requests an interrupt only when mask bit 1 is one.
// - control bit 0 puts the wide counter output or the port latch on port 3 bit 5, latch by default.
// - writes to the four capture registers are ignored; only capture events load them.
// - the narrow high capture register takes the count measured while the input was high.
// - the narrow low capture register takes the count measured while the input was low.
// - each wide capture puts the high byte of the captured value into the wide high capture register.
// - each wide capture puts the low byte of the captured value into the wide low capture register.
// - edge detection takes its input from port 3 bit 1 or port 2 bit 0.
// - port 3 outputs are steered by common control bits 5:4 and bit 0 of each counter control register.
// - register pointer low nibble 0xd maps the timer registers onto working registers, zero selects the normal file.
// - register pointer high nibble selects the 16-byte working register group.
`include "ctcc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ctcc_core #(
    parameter int WIDE_W   = 16,
    parameter int NARROW_W = 8
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // register access through the register pointer
    input  wire ctcc_pkg::ctcc_byte_t register_pointer,
    input  wire ctcc_pkg::ctcc_nib_t  reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire ctcc_pkg::ctcc_byte_t reg_wdata,
    output ctcc_pkg::ctcc_byte_t   reg_rdata,
    output logic                   reg_hit,
    // normal register file selection
    output logic                   normal_file_sel,
    output ctcc_pkg::ctcc_byte_t   normal_file_addr,
    // pins
    input  wire logic              port3_bit1_pin,
    input  wire logic              port2_bit0_pin,
    input  wire logic [2:0]        port3_latch_654,
    output logic                   port3_bit4_pin,
    output logic                   port3_bit5_pin,
    output logic                   port3_bit6_pin,
    // interrupt requests
    output logic                   wide_capture_irq,
    output logic                   wide_timeout_irq
);
    import ctcc_pkg::*;

    if (WIDE_W != 16 || NARROW_W != 8) begin : g_width_check
        $error("ctcc_core serves only a 16-bit wide and an 8-bit narrow counter");
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    // prescale tick: low bits of the free divider all ones
    function automatic logic presc_tick(input logic [2:0] cnt, input ctcc_clk_sel_t sel);
        logic [2:0] mask;
        mask = 3'((4'h1 << sel) - 4'h1);
        return (cnt & mask) == mask;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [WIDE_W-1:0]   wide_cnt_reg,   wide_cnt_next;
    logic                wide_run_reg,   wide_run_next;
    logic                single_reg,     single_next;
    logic                timeout_reg,    timeout_next;
    ctcc_clk_sel_t       clk_sel_reg,    clk_sel_next;
    logic                cap_mask_reg,   cap_mask_next;
    logic                to_mask_reg,    to_mask_next;
    logic                p35_sel_reg,    p35_sel_next;
    ctcc_byte_t          narrow_ctrl_reg, narrow_ctrl_next;
    ctcc_byte_t          common_ctrl_reg, common_ctrl_next;
    ctcc_byte_t          reload_lo_reg,  reload_lo_next;
    ctcc_byte_t          reload_hi_reg,  reload_hi_next;
    ctcc_byte_t          cap16_lo_reg,   cap16_lo_next;
    ctcc_byte_t          cap16_hi_reg,   cap16_hi_next;
    ctcc_byte_t          cap8_lo_reg,    cap8_lo_next;
    ctcc_byte_t          cap8_hi_reg,    cap8_hi_next;
    logic [NARROW_W-1:0] narrow_cnt_reg, narrow_cnt_next;
    logic [2:0]          presc_reg,      presc_next;
    logic                in_prev_reg,    in_prev_next;
    logic                locked_reg,     locked_next;
    logic                wide_out_reg,   wide_out_next;
    logic                narrow_out_reg, narrow_out_next;
    ctcc_byte_t          rdata_reg,      rdata_next;
    logic                p34_reg, p34_next, p35_reg, p35_next, p36_reg, p36_next;
    logic                cap_irq_reg, cap_irq_next, to_irq_reg, to_irq_next;

    // ****************************************************************
    // decode and pin selection
    // ****************************************************************
    logic       bank_timer;
    logic       wr_hit;
    logic       edge_in;
    logic       edge_seen;
    logic       tick;
    logic       terminal;
    logic       measure;
    ctcc_byte_t wide_ctrl_view;

    assign bank_timer       = register_pointer[3:0] == `CTCC_BANK_TIMER;
    assign normal_file_sel  = register_pointer[3:0] == `CTCC_BANK_NORMAL;
    assign normal_file_addr = {register_pointer[7:4], reg_addr};
    assign reg_hit          = bank_timer && (reg_wr || reg_rd);
    assign wr_hit           = bank_timer && reg_wr;
    assign edge_in   = common_ctrl_reg[`CTCC_CC_IN_SEL] ? port2_bit0_pin : port3_bit1_pin;
    assign edge_seen = edge_in != in_prev_reg;                                     // both edges
    assign tick      = presc_tick(presc_reg, clk_sel_reg);
    assign terminal  = wide_run_reg && tick && wide_cnt_reg == `CTCC_RST_WORD;
    assign measure   = common_ctrl_reg[`CTCC_CC_MEASURE];
    assign wide_ctrl_view = {wide_run_reg, single_reg, timeout_reg, clk_sel_reg,
                             cap_mask_reg, to_mask_reg, p35_sel_reg};

    // ****************************************************************
    // next state
    // ****************************************************************
    // one process for all state; hardware sets win over software clears
    always_comb begin
        logic cap_event;
        cap_event        = 1'b0;
        wide_cnt_next    = wide_cnt_reg;
        wide_run_next    = wide_run_reg;
        single_next      = single_reg;
        timeout_next     = timeout_reg;
        clk_sel_next     = clk_sel_reg;
        cap_mask_next    = cap_mask_reg;
        to_mask_next     = to_mask_reg;
        p35_sel_next     = p35_sel_reg;
        narrow_ctrl_next = narrow_ctrl_reg;
        common_ctrl_next = common_ctrl_reg;
        reload_lo_next   = reload_lo_reg;
        reload_hi_next   = reload_hi_reg;
        cap16_lo_next    = cap16_lo_reg;
        cap16_hi_next    = cap16_hi_reg;
        cap8_lo_next     = cap8_lo_reg;
        cap8_hi_next     = cap8_hi_reg;
        narrow_cnt_next  = narrow_cnt_reg;
        locked_next      = locked_reg;
        wide_out_next    = wide_out_reg;
        narrow_out_next  = narrow_out_reg;
        in_prev_next     = edge_in;
        presc_next       = 3'(presc_reg + 3'h1);
        rdata_next       = rdata_reg;

        // software writes; capture registers have no write path
        if (wr_hit) begin
            case (reg_addr)
                `CTCC_OFS_NARROW_CTRL: narrow_ctrl_next = reg_wdata;
                `CTCC_OFS_COMMON_CTRL: common_ctrl_next = reg_wdata;
                `CTCC_OFS_WIDE_CTRL: begin
                    wide_run_next = reg_wdata[`CTCC_WC_RUN];
                    single_next   = reg_wdata[`CTCC_WC_SINGLE];
                    clk_sel_next  = reg_wdata[`CTCC_WC_CLK_HI:`CTCC_WC_CLK_LO];
                    cap_mask_next = reg_wdata[`CTCC_WC_CAP_MASK];
                    to_mask_next  = reg_wdata[`CTCC_WC_TO_MASK];
                    p35_sel_next  = reg_wdata[`CTCC_WC_P35_SEL];
                    if (reg_wdata[`CTCC_WC_TIMEOUT]) begin
                        timeout_next = 1'b0;
                    end
                    // a fresh start loads the reload value and rearms capture
                    if (reg_wdata[`CTCC_WC_RUN] && !wide_run_reg) begin
                        wide_cnt_next = {reload_hi_reg, reload_lo_reg};
                        locked_next   = 1'b0;
                    end
                end
                `CTCC_OFS_RELOAD_LO:   reload_lo_next = reg_wdata;
                `CTCC_OFS_RELOAD_HI:   reload_hi_next = reg_wdata;
                default: ;
            endcase
        end

        // wide counter: down count on prescaled ticks
        if (wide_run_reg && tick) begin
            if (terminal) begin
                timeout_next  = 1'b1;
                wide_out_next = !wide_out_reg;
                if (single_reg && !measure) begin
                    wide_run_next = 1'b0;
                end else begin
                    wide_cnt_next = {reload_hi_reg, reload_lo_reg};
                end
            end else begin
                wide_cnt_next = WIDE_W'(wide_cnt_reg - 16'h0001);
            end
        end

        // wide capture in measurement mode; single pass locks after the first edge
        if (wide_run_reg && measure && edge_seen && !locked_reg) begin
            cap_event     = 1'b1;
            cap16_hi_next = wide_cnt_reg[15:8];
            cap16_lo_next = wide_cnt_reg[7:0];
            wide_cnt_next = {reload_hi_reg, reload_lo_reg};
            locked_next   = single_reg;
        end

        // narrow counter: times each input level, captures on the level change
        if (narrow_ctrl_reg[`CTCC_NC_RUN]) begin
            if (edge_seen) begin
                if (in_prev_reg) begin
                    cap8_hi_next = narrow_cnt_reg;
                end else begin
                    cap8_lo_next = narrow_cnt_reg;
                end
                narrow_cnt_next = `CTCC_RST_BYTE;
                narrow_out_next = !narrow_out_reg;
            end else if (narrow_cnt_reg != 8'hff) begin
                narrow_cnt_next = NARROW_W'(narrow_cnt_reg + 8'h01);               // saturates
            end
        end

        // pins: port latch unless the control bits hand the pin to a counter
        p34_next = narrow_ctrl_reg[`CTCC_NC_P34_SEL] ? narrow_out_reg
                                                     : port3_latch_654[0];
        p35_next = p35_sel_reg ? wide_out_reg : port3_latch_654[1];
        case (ctcc_p36_sel_t'(common_ctrl_reg[`CTCC_CC_P36_HI:`CTCC_CC_P36_LO]))
            CTCC_P36_LATCH:  p36_next = port3_latch_654[2];
            CTCC_P36_WIDE:   p36_next = wide_out_reg;
            CTCC_P36_NARROW: p36_next = narrow_out_reg;
            CTCC_P36_AND:    p36_next = wide_out_reg & narrow_out_reg;
            default:         p36_next = port3_latch_654[2];
        endcase

        // interrupt requests as one-cycle pulses
        cap_irq_next = cap_event && cap_mask_reg;
        to_irq_next  = terminal && to_mask_reg;

        // read data, registered for the cycle after the request
        if (bank_timer && reg_rd) begin
            case (reg_addr)
                `CTCC_OFS_NARROW_CTRL: rdata_next = narrow_ctrl_reg;
                `CTCC_OFS_COMMON_CTRL: rdata_next = common_ctrl_reg;
                `CTCC_OFS_WIDE_CTRL:   rdata_next = wide_ctrl_view;
                `CTCC_OFS_RELOAD_LO:   rdata_next = reload_lo_reg;
                `CTCC_OFS_RELOAD_HI:   rdata_next = reload_hi_reg;
                `CTCC_OFS_CAP16_LO:    rdata_next = cap16_lo_reg;
                `CTCC_OFS_CAP16_HI:    rdata_next = cap16_hi_reg;
                `CTCC_OFS_CAP8_LO:     rdata_next = cap8_lo_reg;
                `CTCC_OFS_CAP8_HI:     rdata_next = cap8_hi_reg;
                default:               rdata_next = `CTCC_RST_BYTE;
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wide_cnt_reg    <= `CTCC_RST_WORD;
            wide_run_reg    <= 1'b0;
            single_reg      <= 1'b0;
            timeout_reg     <= 1'b0;
            clk_sel_reg     <= `CTCC_RST_CLK_SEL;
            cap_mask_reg    <= 1'b0;
            to_mask_reg     <= 1'b0;
            p35_sel_reg     <= 1'b0;
            narrow_ctrl_reg <= `CTCC_RST_BYTE;
            common_ctrl_reg <= `CTCC_RST_BYTE;
            reload_lo_reg   <= `CTCC_RST_BYTE;
            reload_hi_reg   <= `CTCC_RST_BYTE;
            cap16_lo_reg    <= `CTCC_RST_BYTE;
            cap16_hi_reg    <= `CTCC_RST_BYTE;
            cap8_lo_reg     <= `CTCC_RST_BYTE;
            cap8_hi_reg     <= `CTCC_RST_BYTE;
            narrow_cnt_reg  <= `CTCC_RST_BYTE;
            presc_reg       <= `CTCC_RST_PRESC;
            in_prev_reg     <= 1'b0;
            locked_reg      <= 1'b0;
            wide_out_reg    <= 1'b0;
            narrow_out_reg  <= 1'b0;
            rdata_reg       <= `CTCC_RST_BYTE;
            p34_reg         <= 1'b0;
            p35_reg         <= 1'b0;
            p36_reg         <= 1'b0;
            cap_irq_reg     <= 1'b0;
            to_irq_reg      <= 1'b0;
        end else begin
            wide_cnt_reg    <= wide_cnt_next;
            wide_run_reg    <= wide_run_next;
            single_reg      <= single_next;
            timeout_reg     <= timeout_next;
            clk_sel_reg     <= clk_sel_next;
            cap_mask_reg    <= cap_mask_next;
            to_mask_reg     <= to_mask_next;
            p35_sel_reg     <= p35_sel_next;
            narrow_ctrl_reg <= narrow_ctrl_next;
            common_ctrl_reg <= common_ctrl_next;
            reload_lo_reg   <= reload_lo_next;
            reload_hi_reg   <= reload_hi_next;
            cap16_lo_reg    <= cap16_lo_next;
            cap16_hi_reg    <= cap16_hi_next;
            cap8_lo_reg     <= cap8_lo_next;
            cap8_hi_reg     <= cap8_hi_next;
            narrow_cnt_reg  <= narrow_cnt_next;
            presc_reg       <= presc_next;
            in_prev_reg     <= in_prev_next;
            locked_reg      <= locked_next;
            wide_out_reg    <= wide_out_next;
            narrow_out_reg  <= narrow_out_next;
            rdata_reg       <= rdata_next;
            p34_reg         <= p34_next;
            p35_reg         <= p35_next;
            p36_reg         <= p36_next;
            cap_irq_reg     <= cap_irq_next;
            to_irq_reg      <= to_irq_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata        = rdata_reg;
    assign port3_bit4_pin   = p34_reg;
    assign port3_bit5_pin   = p35_reg;
    assign port3_bit6_pin   = p36_reg;
    assign wide_capture_irq = cap_irq_reg;
    assign wide_timeout_irq = to_irq_reg;

endmodule // ctcc_core

`default_nettype wire

// [core/ctcc_regs.svh]
// register offsets, field positions and reset values of the counter/timer control block
// assumes: included by the core only, no other dependency
`ifndef CTCC_REGS_SVH
`define CTCC_REGS_SVH

// ****************************************************************
// bank selection in the register pointer low nibble
// ****************************************************************
`define CTCC_BANK_NORMAL     4'h0
`define CTCC_BANK_TIMER      4'hd

// ****************************************************************
// working register offsets inside the timer bank
// ****************************************************************
`define CTCC_OFS_NARROW_CTRL 4'h0
`define CTCC_OFS_COMMON_CTRL 4'h1
`define CTCC_OFS_WIDE_CTRL   4'h2
`define CTCC_OFS_RELOAD_LO   4'h6
`define CTCC_OFS_RELOAD_HI   4'h7
`define CTCC_OFS_CAP16_LO    4'h8
`define CTCC_OFS_CAP16_HI    4'h9
`define CTCC_OFS_CAP8_LO     4'ha
`define CTCC_OFS_CAP8_HI     4'hb

// ****************************************************************
// field positions
// ****************************************************************
`define CTCC_WC_RUN          7
`define CTCC_WC_SINGLE       6
`define CTCC_WC_TIMEOUT      5
`define CTCC_WC_CLK_HI       4
`define CTCC_WC_CLK_LO       3
`define CTCC_WC_CAP_MASK     2
`define CTCC_WC_TO_MASK      1
`define CTCC_WC_P35_SEL      0
`define CTCC_CC_IN_SEL       7
`define CTCC_CC_MEASURE      6
`define CTCC_CC_P36_HI       5
`define CTCC_CC_P36_LO       4
`define CTCC_NC_RUN          7
`define CTCC_NC_P34_SEL      0

// ****************************************************************
// reset values
// ****************************************************************
`define CTCC_RST_BYTE        8'h00
`define CTCC_RST_WORD        16'h0000
`define CTCC_RST_CLK_SEL     2'h0
`define CTCC_RST_PRESC       3'h0

`endif

// [core/ctcc_pkg.sv]
// types shared by the counter/timer control block
// assumes: nothing beyond the register header
package ctcc_pkg;
    typedef logic [7:0]  ctcc_byte_t;
    typedef logic [3:0]  ctcc_nib_t;
    typedef logic [1:0]  ctcc_clk_sel_t;
    // routing of the shared port 3 bit 6 output
    typedef enum logic [1:0] {
        CTCC_P36_LATCH,
        CTCC_P36_WIDE,
        CTCC_P36_NARROW,
        CTCC_P36_AND
    } ctcc_p36_sel_t;
endpackage

// [dv/ctcc_properties.sv]
// port-level checks of the counter/timer control block
// assumes: bound to ctcc_core from the bench top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ctcc_check (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 reset,
    // register access
    input wire ctcc_pkg::ctcc_byte_t register_pointer,
    input wire ctcc_pkg::ctcc_nib_t  reg_addr,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire ctcc_pkg::ctcc_byte_t reg_wdata,
    input wire ctcc_pkg::ctcc_byte_t reg_rdata,
    input wire logic                 reg_hit,
    input wire logic                 normal_file_sel,
    input wire ctcc_pkg::ctcc_byte_t normal_file_addr,
    // pins and requests
    input wire logic [2:0]           port3_latch_654,
    input wire logic                 port3_bit5_pin,
    input wire logic                 wide_capture_irq,
    input wire logic                 wide_timeout_irq
);
    import ctcc_pkg::*;
    logic [2:0] msk_reg;
    wire logic  bank_d = register_pointer[3:0] == 4'hd;
    // shadow of the low control bits, taken from write traffic so no internal probe is needed
    always_ff @(posedge clk_sys) begin
        if (reset) msk_reg <= 3'h0;
        else if (reg_wr && bank_d && reg_addr == 4'h2) msk_reg <= reg_wdata[2:0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // single-pass left off so the run bit cannot drop between write and read
    sequence s_ctl_wr;
        reg_wr && bank_d && reg_addr == 4'h2 && !reg_wdata[6];
    endsequence
    sequence s_ctl_rd;
        reg_rd && bank_d && reg_addr == 4'h2;
    endsequence
    property p_ctl_back;
        s_ctl_wr ##2 s_ctl_rd |=> reg_rdata[7] == $past(reg_wdata[7], 3)
            && reg_rdata[4:0] == $past(reg_wdata[4:0], 3);
    endproperty
    property p_hit;
        reg_hit == ((reg_wr || reg_rd) && bank_d);
    endproperty
    property p_norm_sel;
        normal_file_sel == (register_pointer[3:0] == 4'h0);
    endproperty
    property p_group;
        normal_file_addr == {register_pointer[7:4], reg_addr};
    endproperty
    property p_unmapped;
        reg_rd && bank_d && (reg_addr inside {[4'h3:4'h5], [4'hc:4'hf]}) |=> reg_rdata == 8'h00;
    endproperty
    property p_cap_irq;
        wide_capture_irq |-> msk_reg[2] || $past(msk_reg[2]);
    endproperty
    property p_to_irq;
        wide_timeout_irq |-> msk_reg[1] || $past(msk_reg[1]);
    endproperty
    // the first two edges after reset are skipped: the pin is still cleared at the first
    property p_p35;
        !msk_reg[0] && !$past(msk_reg[0]) && !$past(reset) && !$past(reset, 2)
            |-> port3_bit5_pin == $past(port3_latch_654[1]);
    endproperty
    a_ctl_back: assert property (p_ctl_back) else $error("control readback differs");
    a_hit: assert property (p_hit) else $error("bank hit wrong");
    a_norm_sel: assert property (p_norm_sel) else $error("normal file select wrong");
    a_group: assert property (p_group) else $error("working group address wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_cap_irq: assert property (p_cap_irq) else $error("capture request while masked");
    a_to_irq: assert property (p_to_irq) else $error("timeout request while masked");
    a_p35: assert property (p_p35) else $error("pin 5 not following latch");
endmodule // ctcc_check
`default_nettype wire

// [dv/ctcc_pulse_model.sv]
// pulse source standing for the signals on the edge input pins
// assumes: same clock as the block, levels last a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module ctcc_pulse_model (
    // clock and control
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       run,
    input wire logic [7:0] hi_cycles,
    input wire logic [7:0] lo_cycles,
    // pins
    output logic           port3_bit1_pin,
    output logic           port2_bit0_pin
);
    logic [7:0] cnt_reg;
    // the wave only moves while enabled, so idle stretches show quiet lines
    always_ff @(posedge clk_sys) begin
        if (reset || !run) begin
            cnt_reg <= 8'h01;
            port3_bit1_pin <= 1'b0;
        end else if (cnt_reg == (port3_bit1_pin ? hi_cycles : lo_cycles)) begin
            cnt_reg <= 8'h01;
            port3_bit1_pin <= ~port3_bit1_pin;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    // inverted copy, so high and low times swap when this pin is chosen
    assign port2_bit0_pin = ~port3_bit1_pin;
endmodule // ctcc_pulse_model
`default_nettype wire

// [dv/ctcc_tb_top.sv]
// self-checking bench for the counter/timer control block
// assumes: package, core, checker and pulse model compiled before this file
`timescale 1ns/1ps
`default_nettype none
module counter_timer_capture_control_tb_top;
    import ctcc_pkg::*;
    logic       clk_sys = 1'b0;
    logic       reset = 1'b1;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       pulse_run = 1'b0;
    logic [2:0] port3_latch_654 = 3'h0;
    logic [31:0] seed = 32'hfc49;
    ctcc_byte_t register_pointer = 8'h3d;
    ctcc_byte_t reg_wdata = 8'h00;
    ctcc_byte_t got;
    ctcc_nib_t  reg_addr = 4'h0;
    wire ctcc_byte_t reg_rdata, normal_file_addr;
    wire logic  reg_hit, normal_file_sel, port3_bit1_pin, port2_bit0_pin, port3_bit4_pin;
    wire logic  port3_bit5_pin, port3_bit6_pin, wide_capture_irq, wide_timeout_irq;
    int         bad_count = 0;
    int         comparisons = 0;
    int         n, k;
    int         mdl [16];
    ctcc_core uut (.clk_sys, .reset, .register_pointer, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_hit, .normal_file_sel, .normal_file_addr, .port3_bit1_pin,
        .port2_bit0_pin, .port3_latch_654, .port3_bit4_pin, .port3_bit5_pin, .port3_bit6_pin,
        .wide_capture_irq, .wide_timeout_irq);
    ctcc_pulse_model pulse (.clk_sys, .reset, .run(pulse_run), .hi_cycles(8'h14),
        .lo_cycles(8'h28), .port3_bit1_pin, .port2_bit0_pin);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
    endfunction
    initial forever #5 clk_sys = ~clk_sys;
    // latch bits wander every cycle so the port path is exercised throughout
    always @(posedge clk_sys) begin
        seed <= lfsr(seed);
        port3_latch_654 <= seed[2:0];
    end
    task automatic chk(input ctcc_byte_t g, input ctcc_byte_t e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input ctcc_nib_t a, input ctcc_byte_t d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        if (register_pointer[3:0] == 4'hd && a inside {0, 1, 2, 6, 7}) mdl[a] = d;
    endtask
    task automatic rd(input ctcc_nib_t a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    // bounded wait for one request pulse; n holds the cycles spent
    task automatic wait_irq(input logic cap);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while ((cap ? wide_capture_irq : wide_timeout_irq) !== 1'b1 && n < 300);
    endtask
    task automatic count_cap(input int cycles);
        k = 0;
        repeat (cycles) begin
            @(posedge clk_sys);
            #1 if (wide_capture_irq === 1'b1) k++;
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        conclude();
    end
    initial begin
        foreach (mdl[i]) mdl[i] = 0;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0]);
            chk(got, 8'h00);
        end
        // random control words, single-pass off so the run bit holds
        for (int i = 0; i < 6; i++) begin
            wr(4'h2, seed[7:0] & 8'hbf);
            rd(4'h2);
            chk(got & 8'hdf, 8'(mdl[2]) & 8'hdf);
        end
        wr(4'h2, 8'h20);
        register_pointer <= 8'h30;
        wr(4'h6, 8'h5a);
        register_pointer <= 8'h3d;
        rd(4'h6);
        chk(got, 8'(mdl[6]));
        for (int a = 8; a < 12; a++) wr(a[3:0], 8'hff);
        for (int a = 8; a < 12; a++) begin
            rd(a[3:0]);
            chk(got, 8'h00);
        end
        wr(4'h6, 8'h05);
        wr(4'h7, 8'h00);
        wr(4'h2, 8'hc2);
        wait_irq(1'b0);
        chk(8'(n < 300), 8'h01);
        rd(4'h2);
        chk(got, 8'h62);
        wr(4'h2, 8'h42);
        rd(4'h2);
        chk(got, 8'h62);
        wr(4'h2, 8'h60);
        rd(4'h2);
        chk(got, 8'h40);
        // modulo-4 period scales with each prescale code
        wr(4'h6, 8'h03);
        for (int c = 0; c < 4; c++) begin
            wr(4'h2, 8'h82 | 8'(c << 3));
            wait_irq(1'b0);
            wait_irq(1'b0);
            wait_irq(1'b0);
            chk(8'(n), 8'(4 << c));
        end
        wr(4'h2, 8'h20);
        wr(4'h1, 8'h40);
        wr(4'h6, 8'hff);
        wr(4'h7, 8'hff);
        pulse_run <= 1'b1;
        wr(4'h2, 8'h84);
        wait_irq(1'b1);
        count_cap(190);
        chk(8'(k), 8'h06);
        rd(4'h9);
        chk(got, 8'hff);
        rd(4'h8);
        chk(8'(got inside {[8'he9:8'hed], [8'hd5:8'hd9]}), 8'h01);
        wr(4'h2, 8'h00);
        wr(4'h2, 8'hc4);
        count_cap(190);
        chk(8'(k), 8'h01);
        wr(4'h2, 8'h01);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h81);
        repeat (200) @(posedge clk_sys);
        rd(4'hb);
        chk(8'(got inside {[8'h12:8'h16]}), 8'h01);
        rd(4'ha);
        chk(8'(got inside {[8'h26:8'h2a]}), 8'h01);
        wr(4'h1, 8'hb0);
        repeat (200) @(posedge clk_sys);
        rd(4'hb);
        chk(8'(got inside {[8'h26:8'h2a]}), 8'h01);
        chk(8'(port3_bit6_pin), 8'(port3_bit4_pin & port3_bit5_pin));
        conclude();
    end
endmodule // counter_timer_capture_control_tb_top
bind ctcc_core ctcc_check chk_i (.clk_sys, .reset, .register_pointer, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_hit, .normal_file_sel, .normal_file_addr, .port3_latch_654,
    .port3_bit5_pin, .wide_capture_irq, .wide_timeout_irq);
`default_nettype wire
